// ===== rtl/psm_supervisor.sv
/*
 * Power supply mode supervisor: OTP load, supply lockout, protection
 * and auto-restart, burst standby, AC unplug with X-cap discharge, and
 * PFC valley-mode cycle control. Assumes synchronous sense decisions,
 * an OTP array that returns the word of the previous cycle's address,
 * and a register master with one-cycle strobes.
 */
`timescale 1ns/100ps
module psm_supervisor #(
  parameter int TICK_CYCLES = psm_pkg::MS_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire psm_pkg::psm_sense_t sense_in,
  input wire logic [7:0] pi_scale_in,
  input wire logic [15:0] ontime_in,
  input wire logic [15:0] otp_data_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic [3:0] otp_addr_out,
  output logic pfc_gate_out,
  output logic llc_enable_out,
  output logic [3:0] llc_soft_level_out,
  output logic hv_cell_out,
  output psm_pkg::psm_mode_t mode_out
);

  // ============================================================
  // State
  psm_pkg::psm_state_t st_reg;
  psm_pkg::psm_state_t st_next;
  logic ms_tick;
  logic operating;
  logic protect;
  logic xcap_en;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
  endfunction : sat_inc

  // Shared decodes of the current state
  assign ms_tick = (st_reg.tick_cnt == 16'(TICK_CYCLES - 1));
  assign xcap_en = st_reg.cfg[psm_pkg::CFG_CTRL][psm_pkg::CTRL_XCAP_BIT];
  assign operating = (st_reg.mode == psm_pkg::PSM_SOFTSTART) ||
                     (st_reg.mode == psm_pkg::PSM_NORMAL) ||
                     (st_reg.mode == psm_pkg::PSM_BURST_PAUSE) ||
                     (st_reg.mode == psm_pkg::PSM_BURST_ON);
  assign protect = operating && (sense_in.temp_otp ||
    (st_reg.ovp_cnt >= st_reg.cfg[psm_pkg::CFG_OVP_BLK]));

  // ============================================================
  // Next state
  always_comb begin
    logic [23:0] prod;
    logic [19:0] comp;
    logic [15:0] ton_new;
    logic [3:0] valley_new;
    logic [15:0] remain;
    logic start;
    prod = '0;
    comp = '0;
    ton_new = '0;
    valley_new = '0;
    remain = '0;
    start = 1'b0;
    st_next = st_reg;
    st_next.tick_cnt = ms_tick ? 16'h0000 : 16'(st_reg.tick_cnt + 16'h0001);

    // Register port: read data stands one cycle after the strobe
    st_next.rdata = 16'h0000;
    if (reg_rd_in) begin
      if (reg_addr_in < psm_pkg::CFG_WORDS) begin
        st_next.rdata = st_reg.cfg[reg_addr_in];
      end else if (reg_addr_in == psm_pkg::REG_STATUS) begin
        st_next.rdata = {7'h00, st_reg.unplug, st_reg.valley, 1'b0,
                         st_reg.mode};
      end
    end
    if (reg_wr_in && (reg_addr_in < psm_pkg::CFG_WORDS)) begin
      st_next.cfg[reg_addr_in] = reg_wdata_in;
    end

    // AC unplug: time since last mains pulse
    if (st_reg.mode != psm_pkg::PSM_LOAD) begin
      if (sense_in.mf_pulse) begin
        st_next.ac_cnt = 16'h0000;
        st_next.unplug = 1'b0;
      end else if (ms_tick) begin
        st_next.ac_cnt = sat_inc(st_reg.ac_cnt);
      end
      if (!sense_in.mf_pulse &&
          st_reg.ac_cnt >= psm_pkg::UNPLUG_BLANK_MS) begin
        st_next.unplug = 1'b1;
      end
    end

    // Blanking counters restart when their condition drops
    if (st_reg.mode == psm_pkg::PSM_NORMAL && sense_in.fb_burst_enter) begin
      if (ms_tick) st_next.blank_cnt = sat_inc(st_reg.blank_cnt);
    end else begin
      st_next.blank_cnt = 16'h0000;
    end
    if (sense_in.vcc_ovp) begin
      if (ms_tick) st_next.ovp_cnt = sat_inc(st_reg.ovp_cnt);
    end else begin
      st_next.ovp_cnt = 16'h0000;
    end

    // Mode sequencing
    case (st_reg.mode)
      psm_pkg::PSM_LOAD: begin
        if (st_reg.ld_idx != 4'h0) begin
          st_next.cfg[4'(st_reg.ld_idx - 4'h1)] = otp_data_in;
        end
        if (st_reg.ld_idx == psm_pkg::CFG_WORDS) begin
          st_next.mode = psm_pkg::PSM_STARTUP;
        end else begin
          st_next.ld_idx = 4'(st_reg.ld_idx + 4'h1);
        end
        // Address equals the index, so data of ld_idx-1 arrives now
        st_next.otp_addr = st_next.ld_idx;
      end
      psm_pkg::PSM_STARTUP: begin
        if (sense_in.vcc_on) st_next.mode = psm_pkg::PSM_SOFTSTART;
      end
      psm_pkg::PSM_SOFTSTART, psm_pkg::PSM_NORMAL,
      psm_pkg::PSM_BURST_PAUSE, psm_pkg::PSM_BURST_ON: begin
        if (sense_in.vcc_off) begin
          st_next.mode = psm_pkg::PSM_STARTUP;
        end else if (protect) begin
          st_next.mode = psm_pkg::PSM_AUTO_RESTART;
          st_next.ar_cnt = 16'h0000;
        end else if (st_reg.mode == psm_pkg::PSM_SOFTSTART) begin
          if (sense_in.bus_target) st_next.mode = psm_pkg::PSM_NORMAL;
        end else if (st_reg.mode == psm_pkg::PSM_NORMAL) begin
          if (st_reg.blank_cnt >= st_reg.cfg[psm_pkg::CFG_BURST_BLK]) begin
            st_next.mode = psm_pkg::PSM_BURST_PAUSE;
            st_next.off_cnt = 16'h0000;
            st_next.wake_lim = 16'hFFFF;
          end
        end else if (sense_in.fb_burst_exit) begin
          st_next.mode = psm_pkg::PSM_NORMAL;
        end else if (st_reg.mode == psm_pkg::PSM_BURST_PAUSE) begin
          if (sense_in.fb_burst_wake || sense_in.vcc_burst_wake ||
              st_reg.off_cnt >= st_reg.wake_lim) begin
            if (st_reg.off_cnt <= st_reg.cfg[psm_pkg::CFG_OFF_MIN]) begin
              st_next.mode = psm_pkg::PSM_NORMAL;
            end else begin
              st_next.mode = psm_pkg::PSM_BURST_ON;
              st_next.burst_cnt = 16'h0000;
            end
            if (st_reg.off_cnt > st_reg.cfg[psm_pkg::CFG_OFF_MAX]) begin
              // Move forced wake halfway toward the off-time target
              st_next.wake_lim = 16'(({1'b0, st_reg.off_cnt} +
                {1'b0, st_reg.cfg[psm_pkg::CFG_OFF_MAX]}) >> 1);
            end
          end else if (ms_tick) begin
            st_next.off_cnt = sat_inc(st_reg.off_cnt);
          end
        end else begin
          if (st_reg.burst_cnt >= st_reg.cfg[psm_pkg::CFG_BURST_ON]) begin
            st_next.mode = psm_pkg::PSM_BURST_PAUSE;
            st_next.off_cnt = 16'h0000;
          end else if (ms_tick) begin
            st_next.burst_cnt = sat_inc(st_reg.burst_cnt);
          end
        end
      end
      psm_pkg::PSM_AUTO_RESTART: begin
        if (st_reg.ar_cnt >= st_reg.cfg[psm_pkg::CFG_AR_BREAK]) begin
          if (sense_in.temp_release) begin
            st_next.mode = psm_pkg::PSM_STARTUP;
          end else begin
            st_next.ar_cnt = 16'h0000;
          end
        end else if (ms_tick) begin
          st_next.ar_cnt = sat_inc(st_reg.ar_cnt);
        end
      end
      default: begin
        st_next.mode = psm_pkg::PSM_LOAD;
      end
    endcase

    // PFC on-time and valley choice for a new cycle
    prod = 24'(st_reg.cfg[psm_pkg::CFG_MIN_ON] * pi_scale_in);
    valley_new = st_reg.valley;
    if (st_reg.mode == psm_pkg::PSM_SOFTSTART) begin
      valley_new = 4'h1;
      ton_new = prod[19:4];
    end else begin
      if (st_reg.period_cnt < st_reg.cfg[psm_pkg::CFG_PER_MIN] &&
          st_reg.valley < psm_pkg::VALLEY_DCM) begin
        valley_new = 4'(st_reg.valley + 4'h1);
      end else if (st_reg.period_cnt > st_reg.cfg[psm_pkg::CFG_PER_MAX] &&
                   st_reg.valley > 4'h1) begin
        valley_new = 4'(st_reg.valley - 4'h1);
      end
      comp = 20'((st_reg.ton_hold >> 3) * 4'(valley_new - 4'h1));
      ton_new = 16'(st_reg.ton_hold + comp[15:0]);
    end
    if (ton_new == 16'h0000) ton_new = 16'h0001;

    // On-time held over a mains cycle
    if (sense_in.mf_pulse || st_reg.pfc_ph == psm_pkg::PSM_PFC_IDLE) begin
      st_next.ton_hold = ontime_in;
    end

    // PFC switching cycle
    st_next.period_cnt = sat_inc(st_reg.period_cnt);
    if (st_reg.mode != psm_pkg::PSM_SOFTSTART &&
        st_reg.mode != psm_pkg::PSM_NORMAL) begin
      st_next.pfc_ph = psm_pkg::PSM_PFC_IDLE;
      st_next.valley = 4'h1;
    end else begin
      case (st_reg.pfc_ph)
        psm_pkg::PSM_PFC_IDLE: start = 1'b1;
        psm_pkg::PSM_PFC_ON: begin
          st_next.pfc_cnt = sat_inc(st_reg.pfc_cnt);
          if (st_next.pfc_cnt >= st_reg.ton) begin
            st_next.pfc_ph = psm_pkg::PSM_PFC_FREE;
          end
        end
        psm_pkg::PSM_PFC_FREE: begin
          if (sense_in.zcd) begin
            if (st_reg.valley == 4'h1) begin
              start = 1'b1;
            end else begin
              st_next.pfc_ph = psm_pkg::PSM_PFC_WAIT;
              st_next.valley_seen = 4'h0;
            end
          end
        end
        psm_pkg::PSM_PFC_WAIT: begin
          if (sense_in.valley) begin
            st_next.valley_seen = 4'(st_reg.valley_seen + 4'h1);
          end
          if ((sense_in.valley && st_reg.valley <= psm_pkg::VALLEY_MAX &&
               4'(st_reg.valley_seen + 4'h2) >= st_reg.valley) ||
              st_reg.period_cnt >= st_reg.cfg[psm_pkg::CFG_PER_MAX]) begin
            start = 1'b1;
          end
        end
        default: st_next.pfc_ph = psm_pkg::PSM_PFC_IDLE;
      endcase
    end
    if (start) begin
      st_next.pfc_ph = psm_pkg::PSM_PFC_ON;
      st_next.pfc_cnt = 16'h0000;
      st_next.period_cnt = 16'h0000;
      st_next.valley = valley_new;
      st_next.ton = ton_new;
    end

    // Output drives, registered with the state
    st_next.gate = (st_next.pfc_ph == psm_pkg::PSM_PFC_ON) &&
      (st_next.mode == psm_pkg::PSM_SOFTSTART ||
       st_next.mode == psm_pkg::PSM_NORMAL);
    st_next.llc_en = (st_next.mode == psm_pkg::PSM_SOFTSTART) ||
                     (st_next.mode == psm_pkg::PSM_NORMAL) ||
                     (st_next.mode == psm_pkg::PSM_BURST_ON);
    remain = 16'(st_reg.cfg[psm_pkg::CFG_BURST_ON] - st_next.burst_cnt);
    if (st_next.mode == psm_pkg::PSM_BURST_ON) begin
      st_next.level = psm_pkg::RAMP_TOP;
      if (st_next.burst_cnt < 16'(psm_pkg::RAMP_TOP)) begin
        st_next.level = st_next.burst_cnt[3:0];
      end
      if (remain < 16'(st_next.level)) st_next.level = remain[3:0];
    end else begin
      st_next.level = st_next.llc_en ? psm_pkg::RAMP_TOP : 4'h0;
    end
    st_next.hv = (st_next.mode == psm_pkg::PSM_STARTUP) ||
                 (st_next.mode == psm_pkg::PSM_AUTO_RESTART) ||
                 (st_next.unplug &&
                  st_next.cfg[psm_pkg::CFG_CTRL][psm_pkg::CTRL_XCAP_BIT]);
  end

  // ============================================================
  // State register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.mode <= psm_pkg::PSM_LOAD;
      st_reg.cfg <= psm_pkg::CFG_RESET;
      st_reg.wake_lim <= 16'hFFFF;
      st_reg.valley <= 4'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_out = st_reg.rdata;
  assign otp_addr_out = st_reg.otp_addr;
  assign pfc_gate_out = st_reg.gate;
  assign llc_enable_out = st_reg.llc_en;
  assign llc_soft_level_out = st_reg.level;
  assign hv_cell_out = st_reg.hv;
  assign mode_out = st_reg.mode;

  // ============================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_burst_done;
    st_reg.mode == psm_pkg::PSM_BURST_ON && !sense_in.vcc_off && !protect &&
    !sense_in.fb_burst_exit &&
    st_reg.burst_cnt >= st_reg.cfg[psm_pkg::CFG_BURST_ON];
  endsequence
  sequence s_paused;
    st_reg.mode == psm_pkg::PSM_BURST_PAUSE && !pfc_gate_out &&
    !llc_enable_out;
  endsequence

  a_unplug_bound: assert property (
    (st_reg.mode != psm_pkg::PSM_LOAD &&
     st_reg.ac_cnt >= psm_pkg::UNPLUG_MAX_MS) |-> st_reg.unplug)
    else $error("unplug not declared in time");
  a_discharge_on: assert property (
    (st_reg.unplug && xcap_en) |-> hv_cell_out)
    else $error("discharge cell off after unplug");
  a_xcap_disabled: assert property (
    (!xcap_en && operating) |-> !hv_cell_out)
    else $error("discharge while disabled");
  a_burst_stop: assert property (
    (st_reg.mode == psm_pkg::PSM_NORMAL && !sense_in.vcc_off && !protect &&
     st_reg.blank_cnt >= st_reg.cfg[psm_pkg::CFG_BURST_BLK]) |=> s_paused)
    else $error("burst entry did not stop switching");
  a_burst_sleep: assert property (s_burst_done |=> s_paused)
    else $error("burst did not return to sleep");
  a_uvlo_off: assert property (
    (operating && sense_in.vcc_off) |=>
    st_reg.mode == psm_pkg::PSM_STARTUP)
    else $error("supply lockout ignored");
  a_ovp_restart: assert property (
    (operating && !sense_in.vcc_off &&
     st_reg.ovp_cnt >= st_reg.cfg[psm_pkg::CFG_OVP_BLK]) |=>
    st_reg.mode == psm_pkg::PSM_AUTO_RESTART)
    else $error("overvoltage did not force restart");
  a_ar_hold: assert property (
    st_reg.mode == psm_pkg::PSM_AUTO_RESTART |->
    hv_cell_out && !pfc_gate_out && !llc_enable_out)
    else $error("auto-restart outputs wrong");
  a_ovp_blank: assert property (
    !sense_in.vcc_ovp |=> st_reg.ovp_cnt == 16'h0000)
    else $error("overvoltage blanking not restarted");
  a_load_first: assert property (
    st_reg.mode == psm_pkg::PSM_LOAD |-> !pfc_gate_out && !llc_enable_out)
    else $error("switching before configuration load");

  // Burst exit, restart sequencing and PFC cycle invariants
  a_burst_exit: assert property (
    ((st_reg.mode == psm_pkg::PSM_BURST_PAUSE ||
      st_reg.mode == psm_pkg::PSM_BURST_ON) && !sense_in.vcc_off &&
     !protect && sense_in.fb_burst_exit) |=>
    st_reg.mode == psm_pkg::PSM_NORMAL)
    else $error("burst exit ignored");
  a_restart_exit: assert property (
    (st_reg.mode == psm_pkg::PSM_AUTO_RESTART && sense_in.temp_release &&
     st_reg.ar_cnt >= st_reg.cfg[psm_pkg::CFG_AR_BREAK]) |=>
    st_reg.mode == psm_pkg::PSM_STARTUP)
    else $error("no startup after break time");
  a_hot_hold: assert property (
    (st_reg.mode == psm_pkg::PSM_AUTO_RESTART && !sense_in.temp_release) |=>
    st_reg.mode == psm_pkg::PSM_AUTO_RESTART)
    else $error("left auto-restart while hot");
  a_gate_phase: assert property (
    pfc_gate_out |-> st_reg.pfc_ph == psm_pkg::PSM_PFC_ON)
    else $error("gate driven outside on-phase");
  a_soft_valley: assert property (
    (st_reg.mode == psm_pkg::PSM_SOFTSTART && pfc_gate_out) |->
    st_reg.valley == 4'h1)
    else $error("softstart not on first valley");
  a_valley_range: assert property (
    st_reg.valley >= 4'h1 && st_reg.valley <= psm_pkg::VALLEY_DCM)
    else $error("valley choice out of range");

endmodule : psm_supervisor

// ===== rtl/psm_pkg.sv
/*
 * Constants, register map and carrier types of the power supply mode
 * supervisor. Assumes a 50 MHz system clock. All sense inputs are
 * already-qualified comparator or ADC decisions, synchronous to that clock.
 */
// Summary of operation
// - Declare AC unplug within 800 ms.
// - On unplug, high voltage cell discharges X-caps.
// - X-cap discharge enabled by configuration bit.
// - Standby unplug needs 240 ms without mains pulses.
// - Low feedback over blanking stops switching, pauses.
// - Feedback or supply wake starts a burst.
// - Burst has fixed length, soft ramp both ends.
// - After one burst, stop and sleep again.
// - Adapt burst rate toward maximum off-time.
// - Feedback at exit level leaves burst mode.
// - Off-time at minimum leaves burst mode.
// - Supply on/off thresholds with hysteresis.
// - Supply overvoltage over blanking forces auto-restart.
// - Over-temperature forces auto-restart until released.
// - Auto-restart stops switching, keeps startup cell on.
// - Break time expiry starts a new startup.
// - PFC cycle: on, freewheel, then waiting.
// - Softstart first valley, scaled on-time, then multimode.
// - Critical conduction: constant on-time, restart at zero.
// - Light load delays to valleys two..ten, DCM.
// - On-time compensated cycle by cycle for valleys.
// - Load configuration from OTP before operating.
package psm_pkg;

  // ============================================================
  // Clock and time
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam logic [15:0] UNPLUG_MAX_MS = 16'h0320;   // 800 ms
  localparam logic [15:0] UNPLUG_BLANK_MS = 16'h00F0; // 240 ms
  localparam logic [3:0] RAMP_TOP = 4'hF;
  localparam logic [3:0] VALLEY_MAX = 4'hA;
  localparam logic [3:0] VALLEY_DCM = 4'hB;

  // ============================================================
  // Register map (word index on the register port)
  localparam logic [3:0] CFG_CTRL = 4'h0;       // bit 0 X-cap discharge
  localparam logic [3:0] CFG_BURST_ON = 4'h1;   // ms
  localparam logic [3:0] CFG_OFF_MAX = 4'h2;    // ms
  localparam logic [3:0] CFG_OFF_MIN = 4'h3;    // ms
  localparam logic [3:0] CFG_BURST_BLK = 4'h4;  // ms
  localparam logic [3:0] CFG_OVP_BLK = 4'h5;    // ms
  localparam logic [3:0] CFG_AR_BREAK = 4'h6;   // ms
  localparam logic [3:0] CFG_MIN_ON = 4'h7;     // cycles
  localparam logic [3:0] CFG_PER_MIN = 4'h8;    // cycles
  localparam logic [3:0] CFG_PER_MAX = 4'h9;    // cycles
  localparam logic [3:0] REG_STATUS = 4'hA;
  localparam logic [3:0] CFG_WORDS = 4'hA;
  localparam int CTRL_XCAP_BIT = 0;

  // Reset values, overwritten by the OTP load
  localparam logic [9:0][15:0] CFG_RESET = {
    16'h1000, 16'h0100, 16'h0032, 16'h03E8, 16'h000A,
    16'h0014, 16'h0005, 16'h0064, 16'h0014, 16'h0001};

  // ============================================================
  // Types
  typedef enum logic [2:0] {
    PSM_LOAD = 3'b000,
    PSM_STARTUP = 3'b001,
    PSM_SOFTSTART = 3'b010,
    PSM_NORMAL = 3'b011,
    PSM_BURST_PAUSE = 3'b100,
    PSM_BURST_ON = 3'b101,
    PSM_AUTO_RESTART = 3'b110
  } psm_mode_t;

  typedef enum logic [1:0] {
    PSM_PFC_IDLE = 2'b00,
    PSM_PFC_ON = 2'b01,
    PSM_PFC_FREE = 2'b10,
    PSM_PFC_WAIT = 2'b11
  } psm_pfc_ph_t;

  typedef struct packed {
    logic fb_burst_enter;  // feedback below burst entry level
    logic fb_burst_wake;   // feedback at burst wake level
    logic fb_burst_exit;   // feedback at burst exit level
    logic vcc_on;          // supply above supply_enable_threshold
    logic vcc_off;         // supply below supply_disable_threshold
    logic vcc_burst_wake;  // supply below burst wake level
    logic vcc_ovp;         // supply above supply_overvoltage_threshold
    logic temp_otp;        // temperature above protection level
    logic temp_release;    // temperature below release level
    logic mf_pulse;        // mains pulse on multi_function_io_pin
    logic bus_target;      // PFC bus at target voltage
    logic zcd;             // inductor current reached zero
    logic valley;          // one drain ringing valley seen
  } psm_sense_t;

  typedef struct packed {
    psm_mode_t mode;
    logic [9:0][15:0] cfg;
    logic [3:0] ld_idx;
    logic [3:0] otp_addr;
    logic [15:0] tick_cnt;
    logic [15:0] blank_cnt;
    logic [15:0] ovp_cnt;
    logic [15:0] ar_cnt;
    logic [15:0] ac_cnt;
    logic [15:0] burst_cnt;
    logic [15:0] off_cnt;
    logic [15:0] wake_lim;
    logic unplug;
    psm_pfc_ph_t pfc_ph;
    logic [15:0] pfc_cnt;
    logic [15:0] period_cnt;
    logic [3:0] valley;
    logic [3:0] valley_seen;
    logic [15:0] ton;
    logic [15:0] ton_hold;
    logic gate;
    logic llc_en;
    logic [3:0] level;
    logic hv;
    logic [15:0] rdata;
  } psm_state_t;

endpackage : psm_pkg

// ===== tb/psm_stage_model.sv
/*
 * Power stage model: OTP word of the previous cycle's address, one mains
 * pulse per period while mains is on, zero current and valley pulses
 * after each gate pulse. Assumes one clock; outputs change after edges.
 */
`timescale 1ns/100ps
module psm_stage_model #(
  parameter logic [9:0][15:0] CFG = '0,
  parameter int MAINS = 200
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] otp_addr_in,
  input wire logic pfc_gate_in,
  input wire logic mains_on_in,
  output logic [15:0] otp_data_out,
  output logic mf_pulse_out,
  output logic zcd_out,
  output logic valley_out
);
  // ============================================================
  // OTP array, mains pulses, ringing after each gate pulse
  int mcnt;
  int rcnt;
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      otp_data_out <= 16'h5A5A;
      mcnt <= 0;
      rcnt <= 0;
      mf_pulse_out <= 1'h0;
      zcd_out <= 1'h0;
      valley_out <= 1'h0;
    end else begin
      // Unused words toggle, never a stale value
      otp_data_out <= (otp_addr_in < 4'hA) ? CFG[otp_addr_in] :
                      ~otp_data_out;
      mcnt <= (mcnt >= MAINS) ? 0 : mcnt + 1;
      mf_pulse_out <= mains_on_in && mcnt == 0;
      rcnt <= pfc_gate_in ? 0 : rcnt + 1;
      zcd_out <= rcnt == 5;
      valley_out <= rcnt > 5 && rcnt % 4 == 2;
    end
  end
endmodule : psm_stage_model

// ===== tb/psm_supervisor_tb.sv
/*
 * Self-checking bench of the mode supervisor: load, startup, burst,
 * protection, auto-restart and unplug sequences. Assumes the stage
 * model for OTP and mains, and ms timers shortened to 10 cycles.
 */
`timescale 1ns/100ps
module psm_supervisor_tb;
  localparam logic [9:0][15:0] CFG = {16'h00C8, 16'h0014, 16'h0008,
    16'h0005, 16'h0003, 16'h0003, 16'h0002, 16'h0014, 16'h0004, 16'h0001};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  psm_pkg::psm_sense_t sns = '0;
  psm_pkg::psm_sense_t sense;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic mains = 1'h1;
  logic mf, zcd, vly, gate, llc, hv, pz;
  logic [15:0] otp_d, rdata, d;
  logic [3:0] otp_a, lvl, lmax;
  psm_pkg::psm_mode_t mode;
  int fails = 0;
  int n_checks = 0;
  int n, w;

  // ============================================================
  // Clock, sense merge, design and stage model
  always #10 clk = ~clk;
  always_comb begin
    sense = sns;
    sense.mf_pulse = mf;
    sense.zcd = zcd;
    sense.valley = vly;
  end
  psm_supervisor #(.TICK_CYCLES(10)) u_psm_supervisor (
    .sys_clk_in(clk), .rst_n_in(rst_n), .sense_in(sense),
    .pi_scale_in(8'h10), .ontime_in(16'h000C), .otp_data_in(otp_d),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .otp_addr_out(otp_a),
    .pfc_gate_out(gate), .llc_enable_out(llc), .llc_soft_level_out(lvl),
    .hv_cell_out(hv), .mode_out(mode));
  psm_stage_model #(.CFG(CFG), .MAINS(200)) u_psm_stage_model (
    .sys_clk_in(clk), .rst_n_in(rst_n), .otp_addr_in(otp_a),
    .pfc_gate_in(gate), .mains_on_in(mains), .otp_data_out(otp_d),
    .mf_pulse_out(mf), .zcd_out(zcd), .valley_out(vly));

  // ============================================================
  // Shared tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bound(input int cnt, input int lim);
    if (cnt > lim) begin
      fails++;
      $display("mismatch t=%0t wait %h limit %h", $time, cnt, lim);
      stop_test();
    end
  endtask : bound
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic wait_mode(input psm_pkg::psm_mode_t m, input int lim);
    n = 0;
    while (mode !== m) begin
      step();
      n++;
      pz |= mode === psm_pkg::PSM_BURST_PAUSE;
      bound(n, lim);
    end
  endtask : wait_mode
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : rd_reg

  // ============================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    chk({13'h0, mode}, 16'h0000);
    rst_n <= 1'h1;
    wait_mode(psm_pkg::PSM_STARTUP, 20);
    chk({15'h0, n <= 12}, 16'h0001);
    for (int i = 0; i < 10; i++) begin
      rd_reg(4'(i));
      chk(d, CFG[i]);
    end
    rd_reg(4'hC);
    chk(d, 16'h0000);
    wr_reg(psm_pkg::CFG_OFF_MAX, 16'h0015);
    rd_reg(psm_pkg::CFG_OFF_MAX);
    chk(d, 16'h0015);
    wr_reg(psm_pkg::REG_STATUS, 16'hFFFF);
    rd_reg(psm_pkg::REG_STATUS);
    chk({13'h0, d[2:0]}, 16'h0001);
    $display("test load done");
    @(posedge clk);
    sns.vcc_on <= 1'h1;
    wait_mode(psm_pkg::PSM_SOFTSTART, 10);
    chk({15'h0, llc}, 16'h0001);
    n = 0;
    while (gate !== 1'h1) begin
      step();
      n++;
      bound(n, 400);
    end
    w = 0;
    while (gate === 1'h1) begin
      step();
      w++;
      bound(w, 400);
    end
    chk(16'(w), 16'h0008);
    @(posedge clk);
    sns.bus_target <= 1'h1;
    wait_mode(psm_pkg::PSM_NORMAL, 40);
    $display("test startup done");
    @(posedge clk);
    sns.fb_burst_enter <= 1'h1;
    repeat (15) @(posedge clk);
    sns.fb_burst_enter <= 1'h0;
    @(posedge clk);
    sns.fb_burst_enter <= 1'h1;
    repeat (15) @(posedge clk);
    #1 chk({13'h0, mode}, 16'h0003);
    wait_mode(psm_pkg::PSM_BURST_PAUSE, 40);
    chk({14'h0, gate, llc}, 16'h0000);
    @(posedge clk);
    sns.fb_burst_enter <= 1'h0;
    sns.fb_burst_wake <= 1'h1;
    wait_mode(psm_pkg::PSM_NORMAL, 5);
    @(posedge clk);
    sns.fb_burst_wake <= 1'h0;
    sns.fb_burst_enter <= 1'h1;
    wait_mode(psm_pkg::PSM_BURST_PAUSE, 40);
    @(posedge clk);
    sns.fb_burst_enter <= 1'h0;
    repeat (300) @(posedge clk);
    sns.vcc_burst_wake <= 1'h1;
    wait_mode(psm_pkg::PSM_BURST_ON, 3);
    chk({12'h0, lvl}, 16'h0000);
    chk({15'h0, llc}, 16'h0001);
    @(posedge clk);
    sns.vcc_burst_wake <= 1'h0;
    n = 0;
    #1 lmax = 4'h0;
    while (mode === psm_pkg::PSM_BURST_ON) begin
      if (lvl > lmax) lmax = lvl;
      step();
      n++;
      bound(n, 100);
    end
    chk({15'h0, n >= 31 && n <= 40}, 16'h0001);
    chk({15'h0, lmax > 4'h0}, 16'h0001);
    chk({13'h0, mode}, 16'h0004);
    chk({11'h0, llc, lvl}, 16'h0000);
    // Long first pause pulls the forced wake to about 25 ms
    wait_mode(psm_pkg::PSM_BURST_ON, 270);
    chk({15'h0, n >= 241 && n <= 262}, 16'h0001);
    @(posedge clk);
    sns.fb_burst_exit <= 1'h1;
    wait_mode(psm_pkg::PSM_NORMAL, 5);
    $display("test burst done");
    @(posedge clk);
    sns.fb_burst_exit <= 1'h0;
    sns.fb_burst_enter <= 1'h1;
    sns.vcc_ovp <= 1'h1;
    pz = 1'h0;
    wait_mode(psm_pkg::PSM_AUTO_RESTART, 40);
    chk({15'h0, n >= 20}, 16'h0001);
    chk({15'h0, pz}, 16'h0000);
    chk({13'h0, hv, llc, gate}, 16'h0004);
    @(posedge clk);
    sns.fb_burst_enter <= 1'h0;
    sns.vcc_ovp <= 1'h0;
    sns.temp_release <= 1'h1;
    wait_mode(psm_pkg::PSM_STARTUP, 80);
    wait_mode(psm_pkg::PSM_NORMAL, 300);
    @(posedge clk);
    sns.temp_otp <= 1'h1;
    sns.temp_release <= 1'h0;
    wait_mode(psm_pkg::PSM_AUTO_RESTART, 5);
    @(posedge clk);
    sns.temp_otp <= 1'h0;
    repeat (150) @(posedge clk);
    #1 chk({13'h0, mode}, 16'h0006);
    @(posedge clk);
    sns.temp_release <= 1'h1;
    wait_mode(psm_pkg::PSM_STARTUP, 80);
    wait_mode(psm_pkg::PSM_NORMAL, 300);
    $display("test protect done");
    // Align to a mains pulse so the silence is timed from it
    n = 0;
    while (mf !== 1'h1) begin
      step();
      n++;
      bound(n, 250);
    end
    @(posedge clk);
    mains <= 1'h0;
    n = 0;
    while (hv !== 1'h1) begin
      step();
      n++;
      bound(n, 8200);
    end
    chk({15'h0, n >= 2380}, 16'h0001);
    chk({15'h0, n <= 8000}, 16'h0001);
    chk({13'h0, mode}, 16'h0003);
    rd_reg(psm_pkg::REG_STATUS);
    chk({15'h0, d[8]}, 16'h0001);
    @(posedge clk);
    mains <= 1'h1;
    repeat (400) @(posedge clk);
    #1 chk({15'h0, hv}, 16'h0000);
    wr_reg(psm_pkg::CFG_CTRL, 16'h0000);
    mains <= 1'h0;
    repeat (2700) @(posedge clk);
    #1 chk({15'h0, hv}, 16'h0000);
    rd_reg(psm_pkg::REG_STATUS);
    chk({15'h0, d[8]}, 16'h0001);
    @(posedge clk);
    sns.vcc_on <= 1'h0;
    sns.vcc_off <= 1'h1;
    repeat (5) @(posedge clk);
    #1 chk({14'h0, llc, gate}, 16'h0000);
    $display("test unplug done");
    stop_test();
  end
endmodule : psm_supervisor_tb
